// ===== verilog/pcd_pkg.sv
package pcd_pkg;
  // ==========================================================
  // Pin positions
  localparam int PIN_SCL       = 0;
  localparam int PIN_SDA       = 1;
  localparam int PIN_RX        = 2;
  localparam int PIN_TX        = 3;
  localparam int PIN_CAPTURE1  = 4;
  localparam int PIN_UART_CLK  = 5;
  localparam int PIN_TIMER1_CK = 6;
  localparam int PIN_TIMER2_CK = 7;
  localparam int NUM_PINS      = 8;
  localparam int NUM_EXT_INT   = 4;
  localparam int MASK_W        = 3;

  // ==========================================================
  // Reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic       RST_BIT  = 1'b0;

  // ==========================================================
  // Spike filter timing
  localparam int CLK_PERIOD_PS = 20000;
  localparam int SPIKE_NS      = 50;
  localparam int SPIKE_CYC     = (SPIKE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int SPIKE_CNT_W   = 2;
endpackage : pcd_pkg

// ===== verilog/pcd_override_if.sv
`timescale 1ns/1ps
interface pcd_override_if;
  logic [7:0] pu_oe;
  logic [7:0] pu_ov;
  logic [7:0] dd_oe;
  logic [7:0] dd_ov;
  logic [7:0] pv_oe;
  logic [7:0] pv_ov;
  logic [7:0] die_oe;
  logic [7:0] die_ov;
  logic [7:0] slew;
  modport src (output pu_oe, pu_ov, dd_oe, dd_ov, pv_oe, pv_ov, die_oe, die_ov, slew);
  modport dst (input  pu_oe, pu_ov, dd_oe, dd_ov, pv_oe, pv_ov, die_oe, die_ov, slew);
endinterface : pcd_override_if

// ===== verilog/pcd_spike_filter.sv
`timescale 1ns/1ps
module pcd_spike_filter
  import pcd_pkg::*;
(
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // Line
  input  wire logic enable,
  input  wire logic line_in,
  output logic      line_out
);
  logic [SPIKE_CNT_W-1:0] cnt_ff;
  logic                   out_ff;

  // ==========================================================
  // Level must persist SPIKE_CYC cycles before it passes
  always_ff @(posedge clk) begin
    if (!rst_n || !enable) begin
      cnt_ff <= '0;
    end else if (line_in == out_ff) begin
      cnt_ff <= '0;
    end else begin
      cnt_ff <= cnt_ff + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      out_ff <= 1'b1;
    end else if (!enable) begin
      out_ff <= line_in;
    end else if (line_in != out_ff && cnt_ff >= SPIKE_CNT_W'(SPIKE_CYC - 1)) begin
      out_ff <= line_in;
    end
  end

  assign line_out = out_ff;
endmodule : pcd_spike_filter

// ===== verilog/pcd_port_override.sv
`timescale 1ns/1ps
// Operation
// - Compatibility mode keeps the high-address port output only.
// - High-address pins carry address bits 15..8, MSB on pin 7.
// - Pins 7..4 overridden when memory enabled and mask below 1..4.
// - Pins 3..0 overridden when memory enabled and mask below 5,6,7,7.
// - Compatibility mode treats mask as zero.
// - UART clock pin direction from its bit; sync mode drives generated clock.
// - Transmitter enabled forces tx pin output, pull-up off, data driven.
// - Receiver enabled forces rx pin input; pull-up follows port bit unless disabled.
// - Two-wire enable hands two lowest pins to data and clock lines.
// - Two-wire lines drive zero, direction from interface outputs: open drain.
// - Two-wire inputs filtered below 50 ns; slew limiting enabled.
// - Low four pins are interrupt inputs; enabled interrupt forces input enable.
// - Pins 7,6,4 feed timer inputs directly without overrides.
// - Compatibility mode withholds uart and two-wire pin functions.
module pcd_port_override
  import pcd_pkg::*;
(
  // Clock and reset
  input  wire logic                   MCLK,
  input  wire logic                   RST_N,
  // Mode and memory
  input  wire logic                   COMPAT_MODE,
  input  wire logic                   EXT_MEMORY_ENABLE,
  input  wire logic [MASK_W-1:0]      HIGH_ADDRESS_MASK,
  input  wire logic [7:0]             ADDRESS_HIGH,
  input  wire logic                   GLOBAL_PULLUP_DISABLE,
  // Port C own controls
  input  wire logic [7:0]             PORTC_OUT,
  input  wire logic [7:0]             PORTC_DIR,
  // Port C pin drive
  output logic      [7:0]             PORTC_PULLUP,
  output logic      [7:0]             PORTC_OE,
  output logic      [7:0]             PORTC_PIN_OUT,
  // Port D own controls
  input  wire logic [7:0]             PORTD_OUT,
  input  wire logic [7:0]             PORTD_DIR,
  // Port D pin drive and sense
  input  wire logic [7:0]             PORTD_PIN_IN,
  output logic      [7:0]             PORTD_PULLUP,
  output logic      [7:0]             PORTD_OE,
  output logic      [7:0]             PORTD_PIN_OUT,
  output logic      [7:0]             PORTD_INPUT_EN,
  output logic      [7:0]             PORTD_SLEW_LIMIT,
  output logic      [7:0]             PORTD_DATA_IN,
  // Second uart
  input  wire logic                   SECOND_UART_TX_ENABLE,
  input  wire logic                   SECOND_UART_RX_ENABLE,
  input  wire logic                   SECOND_UART_SYNC_SELECT,
  input  wire logic                   SECOND_UART_TX_DATA,
  input  wire logic                   SECOND_UART_CLOCK_OUT,
  output logic                        SECOND_UART_RX_DATA,
  output logic                        SECOND_UART_CLOCK_IN,
  // Two-wire interface
  input  wire logic                   TWO_WIRE_ENABLE,
  input  wire logic                   SDA_OUT,
  input  wire logic                   SCL_OUT,
  output logic                        SDA_IN,
  output logic                        SCL_IN,
  // Timers and interrupts
  input  wire logic [NUM_EXT_INT-1:0] EXT_INT_ENABLE,
  output logic      [NUM_EXT_INT-1:0] EXT_INT_IN,
  output logic                        TIMER1_CLOCK_INPUT,
  output logic                        TIMER2_CLOCK_INPUT,
  output logic                        TIMER1_CAPTURE_INPUT
);

  pcd_override_if ovc ();
  pcd_override_if ovd ();

  // ==========================================================
  // Shared per-pin mux
  function automatic logic [7:0] pick(input logic [7:0] oe, input logic [7:0] ov, input logic [7:0] own);
    pick = (oe & ov) | (~oe & own);
  endfunction

  logic [MASK_W-1:0] eff_mask;
  logic              uart_ok;
  logic              tw_ok;
  logic              sda_filt;
  logic              scl_filt;
  logic [7:0]        nxt_c_pu, nxt_c_oe, nxt_c_pv;
  logic [7:0]        nxt_d_pu, nxt_d_oe, nxt_d_pv, nxt_d_ie;
  logic [7:0]        c_pu_ff, c_oe_ff, c_pv_ff;
  logic [7:0]        d_pu_ff, d_oe_ff, d_pv_ff, d_ie_ff, d_slew_ff;
  logic [7:0]        d_in_ff;

  assign eff_mask = COMPAT_MODE ? '0 : HIGH_ADDRESS_MASK;
  assign uart_ok  = !COMPAT_MODE;
  assign tw_ok    = TWO_WIRE_ENABLE && !COMPAT_MODE;

  // ==========================================================
  // Port C address override
  genvar g;
  generate
    for (g = 0; g < NUM_PINS; g++) begin : g_addr
      // Pin g overridden when mask below 8-g, pins 0 and 1 share limit 7
      localparam int LIMIT = (g == 0) ? 7 : 8 - g;
      logic en;
      assign en = EXT_MEMORY_ENABLE && ({1'b0, eff_mask} < 4'(LIMIT));
      assign ovc.pu_oe[g]  = en;
      assign ovc.pu_ov[g]  = 1'b0;
      assign ovc.dd_oe[g]  = en;
      assign ovc.dd_ov[g]  = 1'b1;
      assign ovc.pv_oe[g]  = en;
      assign ovc.pv_ov[g]  = ADDRESS_HIGH[g];
      assign ovc.die_oe[g] = 1'b0;
      assign ovc.die_ov[g] = 1'b0;
      assign ovc.slew[g]   = 1'b0;
    end
  endgenerate

  always_comb begin
    nxt_c_pu = pick(ovc.pu_oe, ovc.pu_ov, PORTC_OUT & ~PORTC_DIR & {8{!GLOBAL_PULLUP_DISABLE}});
    nxt_c_oe = pick(ovc.dd_oe, ovc.dd_ov, PORTC_DIR);
    nxt_c_pv = pick(ovc.pv_oe, ovc.pv_ov, PORTC_OUT);
    if (COMPAT_MODE) begin
      nxt_c_oe = 8'hFF;
      nxt_c_pu = 8'h00;
    end
  end

  // ==========================================================
  // Port D overrides
  always_comb begin
    ovd.pu_oe  = 8'h00;
    ovd.pu_ov  = 8'h00;
    ovd.dd_oe  = 8'h00;
    ovd.dd_ov  = 8'h00;
    ovd.pv_oe  = 8'h00;
    ovd.pv_ov  = 8'h00;
    ovd.die_oe = 8'h00;
    ovd.die_ov = 8'h00;
    ovd.slew   = 8'h00;
    // Timer pins 7, 6, 4 carry no override
    ovd.pv_oe[PIN_UART_CLK] = uart_ok && SECOND_UART_SYNC_SELECT;
    ovd.pv_ov[PIN_UART_CLK] = SECOND_UART_CLOCK_OUT;
    ovd.pu_oe[PIN_TX] = uart_ok && SECOND_UART_TX_ENABLE;
    ovd.dd_oe[PIN_TX] = uart_ok && SECOND_UART_TX_ENABLE;
    ovd.dd_ov[PIN_TX] = 1'b1;
    ovd.pv_oe[PIN_TX] = uart_ok && SECOND_UART_TX_ENABLE;
    ovd.pv_ov[PIN_TX] = SECOND_UART_TX_DATA;
    ovd.pu_oe[PIN_RX] = uart_ok && SECOND_UART_RX_ENABLE;
    ovd.pu_ov[PIN_RX] = PORTD_OUT[PIN_RX] && !GLOBAL_PULLUP_DISABLE;
    ovd.dd_oe[PIN_RX] = uart_ok && SECOND_UART_RX_ENABLE;
    for (int i = PIN_SCL; i <= PIN_SDA; i++) begin
      ovd.pu_oe[i] = tw_ok;
      ovd.pu_ov[i] = PORTD_OUT[i] && !GLOBAL_PULLUP_DISABLE;
      ovd.dd_oe[i] = tw_ok;
      ovd.pv_oe[i] = tw_ok;
      ovd.slew[i]  = tw_ok;
    end
    ovd.dd_ov[PIN_SDA] = SDA_OUT;
    ovd.dd_ov[PIN_SCL] = SCL_OUT;
    for (int i = 0; i < NUM_EXT_INT; i++) begin
      ovd.die_oe[i] = EXT_INT_ENABLE[i];
      ovd.die_ov[i] = 1'b1;
    end
  end

  always_comb begin
    nxt_d_pu = pick(ovd.pu_oe, ovd.pu_ov, PORTD_OUT & ~PORTD_DIR & {8{!GLOBAL_PULLUP_DISABLE}});
    nxt_d_oe = pick(ovd.dd_oe, ovd.dd_ov, PORTD_DIR);
    nxt_d_pv = pick(ovd.pv_oe, ovd.pv_ov, PORTD_OUT);
    nxt_d_ie = pick(ovd.die_oe, ovd.die_ov, 8'hFF);
  end

  // ==========================================================
  // Registered pin drive; one cycle of latency for clean outputs
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      c_pu_ff <= RST_BYTE;
      c_oe_ff <= RST_BYTE;
      c_pv_ff <= RST_BYTE;
    end else begin
      c_pu_ff <= nxt_c_pu;
      c_oe_ff <= nxt_c_oe;
      c_pv_ff <= nxt_c_pv;
    end
  end

  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      d_pu_ff   <= RST_BYTE;
      d_oe_ff   <= RST_BYTE;
      d_pv_ff   <= RST_BYTE;
      d_ie_ff   <= RST_BYTE;
      d_slew_ff <= RST_BYTE;
    end else begin
      d_pu_ff   <= nxt_d_pu;
      d_oe_ff   <= nxt_d_oe;
      d_pv_ff   <= nxt_d_pv;
      d_ie_ff   <= nxt_d_ie;
      d_slew_ff <= ovd.slew;
    end
  end

  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      d_in_ff <= RST_BYTE;
    end else begin
      d_in_ff <= PORTD_PIN_IN & nxt_d_ie;
    end
  end

  // ==========================================================
  // Two-wire input filters
  pcd_spike_filter u_sda_filt (
    .clk      (MCLK),
    .rst_n    (RST_N),
    .enable   (tw_ok),
    .line_in  (PORTD_PIN_IN[PIN_SDA]),
    .line_out (sda_filt)
  );

  pcd_spike_filter u_scl_filt (
    .clk      (MCLK),
    .rst_n    (RST_N),
    .enable   (tw_ok),
    .line_in  (PORTD_PIN_IN[PIN_SCL]),
    .line_out (scl_filt)
  );

  // ==========================================================
  // Outputs
  assign PORTC_PULLUP         = c_pu_ff;
  assign PORTC_OE             = c_oe_ff;
  assign PORTC_PIN_OUT        = c_pv_ff;
  assign PORTD_PULLUP         = d_pu_ff;
  assign PORTD_OE             = d_oe_ff;
  assign PORTD_PIN_OUT        = d_pv_ff;
  assign PORTD_INPUT_EN       = d_ie_ff;
  assign PORTD_SLEW_LIMIT     = d_slew_ff;
  assign PORTD_DATA_IN        = d_in_ff;
  assign SECOND_UART_RX_DATA  = d_in_ff[PIN_RX];
  assign SECOND_UART_CLOCK_IN = d_in_ff[PIN_UART_CLK];
  assign SDA_IN               = sda_filt;
  assign SCL_IN               = scl_filt;
  assign EXT_INT_IN           = d_in_ff[NUM_EXT_INT-1:0];
  assign TIMER1_CLOCK_INPUT   = d_in_ff[PIN_TIMER1_CK];
  assign TIMER2_CLOCK_INPUT   = d_in_ff[PIN_TIMER2_CK];
  assign TIMER1_CAPTURE_INPUT = d_in_ff[PIN_CAPTURE1];
endmodule : pcd_port_override

// ===== tb/pcd_port_override_properties.sv
`timescale 1ns/1ps
// ==========================================
// Override checks on the top ports
module pcd_port_override_properties
  import pcd_pkg::*;
(
  // Clock and reset
  input wire logic                   MCLK,
  input wire logic                   RST_N,
  // Controls
  input wire logic                   COMPAT_MODE,
  input wire logic                   EXT_MEMORY_ENABLE,
  input wire logic [MASK_W-1:0]      HIGH_ADDRESS_MASK,
  input wire logic [7:0]             ADDRESS_HIGH,
  input wire logic [7:0]             PORTC_DIR,
  input wire logic                   SECOND_UART_TX_ENABLE,
  input wire logic                   SECOND_UART_TX_DATA,
  input wire logic                   SECOND_UART_RX_ENABLE,
  input wire logic                   TWO_WIRE_ENABLE,
  input wire logic                   SDA_OUT,
  input wire logic [NUM_EXT_INT-1:0] EXT_INT_ENABLE,
  // Pin drive
  input wire logic [7:0]             PORTC_PULLUP,
  input wire logic [7:0]             PORTC_OE,
  input wire logic [7:0]             PORTC_PIN_OUT,
  input wire logic [7:0]             PORTD_OE,
  input wire logic [7:0]             PORTD_PIN_OUT,
  input wire logic [7:0]             PORTD_INPUT_EN,
  input wire logic [7:0]             PORTD_SLEW_LIMIT
);
  logic [7:0] ov;
  logic [7:0] exp_oe;
  logic       tx_on;
  logic       rx_on;
  logic       tw_on;
  // Compat mode withholds the serial pins, so fold it in here once
  assign tx_on = SECOND_UART_TX_ENABLE & ~COMPAT_MODE;
  assign rx_on = SECOND_UART_RX_ENABLE & ~COMPAT_MODE;
  assign tw_on = TWO_WIRE_ENABLE & ~COMPAT_MODE;
  assign exp_oe = COMPAT_MODE ? 8'hFF : (ov | PORTC_DIR);
  always_comb begin
    for (int g = 0; g < 8; g++) begin
      ov[g] = EXT_MEMORY_ENABLE && ((COMPAT_MODE ? 3'h0 : HIGH_ADDRESS_MASK) < (g == 0 ? 7 : 8 - g));
    end
  end
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RST_N);
  property p_c_oe; RST_N |=> PORTC_OE == $past(exp_oe); endproperty
  a_c_oe: assert property (p_c_oe) else $error("port c direction");
  property p_c_val; $past(RST_N) |-> ((PORTC_PIN_OUT ^ $past(ADDRESS_HIGH)) & $past(ov)) == 8'h00; endproperty
  a_c_val: assert property (p_c_val) else $error("port c address");
  property p_c_pu; $past(RST_N) |-> (PORTC_PULLUP & ($past(ov) | {8{$past(COMPAT_MODE)}})) == 8'h00; endproperty
  a_c_pu: assert property (p_c_pu) else $error("port c pullup");
  property p_tx; RST_N && tx_on |=> PORTD_OE[3] && PORTD_PIN_OUT[3] == $past(SECOND_UART_TX_DATA); endproperty
  a_tx: assert property (p_tx) else $error("tx pin");
  property p_rx; RST_N && rx_on |=> !PORTD_OE[2]; endproperty
  a_rx: assert property (p_rx) else $error("rx pin");
  property p_tw; $past(RST_N) && $past(tw_on) |-> PORTD_PIN_OUT[1:0] == 2'h0 && PORTD_OE[1] == $past(SDA_OUT); endproperty
  a_tw: assert property (p_tw) else $error("two-wire drive");
  property p_slew; (RST_N && tw_on) [*2] |-> PORTD_SLEW_LIMIT[1:0] == 2'h3; endproperty
  a_slew: assert property (p_slew) else $error("slew limit");
  property p_int; $past(RST_N) |-> (PORTD_INPUT_EN[3:0] & $past(EXT_INT_ENABLE)) == $past(EXT_INT_ENABLE); endproperty
  a_int: assert property (p_int) else $error("input enable");
  c_compat: cover property (COMPAT_MODE && EXT_MEMORY_ENABLE);
  c_tw: cover property (tw_on ##1 SDA_OUT);
  c_uart: cover property (tx_on && rx_on);
endmodule // pcd_port_override_properties

bind pcd_port_override pcd_port_override_properties i_pcd_port_override_properties (.*);

// ===== tb/pcd_pin_partner.sv
`timescale 1ns/1ps
// ==========================================
// Far side of port D: bus pull-ups on pins 1..0, external drivers
module pcd_pin_partner (
  // Clock
  input  wire logic       clk,
  // Device drive
  input  wire logic [7:0] oe,
  input  wire logic [7:0] pin_out,
  input  wire logic [7:0] pull_en,
  // External drivers
  input  wire logic [7:0] ext_en,
  input  wire logic [7:0] ext_val,
  // Resolved levels
  output logic      [7:0] pin_in
);
  logic [7:0] last_ff = 8'h00;
  // Floating pins flip each cycle, so a stale level never passes
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (i < 2) pin_in[i] = ~((oe[i] & ~pin_out[i]) | (ext_en[i] & ~ext_val[i]));
      else if (oe[i]) pin_in[i] = pin_out[i];
      else if (ext_en[i]) pin_in[i] = ext_val[i];
      else pin_in[i] = pull_en[i] | ~last_ff[i];
    end
  end
  always_ff @(posedge clk) begin
    last_ff <= pin_in;
  end
endmodule // pcd_pin_partner

// ===== tb/pcd_port_override_tb_top.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin bad_count++; $display("BAD %s exp %h got %h", n, e, g); end end
module pcd_port_override_tb_top;
  // ==========================================
  // Signals
  logic       MCLK, RST_N, COMPAT_MODE, EXT_MEMORY_ENABLE, GLOBAL_PULLUP_DISABLE, TWO_WIRE_ENABLE;
  logic [2:0] HIGH_ADDRESS_MASK;
  logic [7:0] ADDRESS_HIGH, PORTC_OUT, PORTC_DIR, PORTD_OUT, PORTD_DIR, PORTD_PIN_IN, ext_en, ext_val;
  logic [7:0] PORTC_PULLUP, PORTC_OE, PORTC_PIN_OUT, PORTD_PULLUP, PORTD_OE, PORTD_PIN_OUT;
  logic [7:0] PORTD_INPUT_EN, PORTD_SLEW_LIMIT, PORTD_DATA_IN;
  logic       SECOND_UART_TX_ENABLE, SECOND_UART_RX_ENABLE, SECOND_UART_SYNC_SELECT, SECOND_UART_TX_DATA;
  logic       SECOND_UART_CLOCK_OUT, SECOND_UART_RX_DATA, SECOND_UART_CLOCK_IN, SDA_OUT, SCL_OUT, SDA_IN, SCL_IN;
  logic       TIMER1_CLOCK_INPUT, TIMER2_CLOCK_INPUT, TIMER1_CAPTURE_INPUT;
  logic [3:0] EXT_INT_ENABLE, EXT_INT_IN;
  int         bad_count = 0;
  int         checks_done = 0;
  pcd_port_override i_pcd_port_override (.*);
  pcd_pin_partner i_pcd_pin_partner (.clk(MCLK), .oe(PORTD_OE), .pin_out(PORTD_PIN_OUT), .pull_en(PORTD_PULLUP),
    .ext_en(ext_en), .ext_val(ext_val), .pin_in(PORTD_PIN_IN));
  initial begin
    MCLK = 1'b0;
    forever #10 MCLK = ~MCLK;
  end
  // ==========================================
  // Tasks
  task automatic tick(input int n);
    repeat (n) @(negedge MCLK);
  endtask
  task automatic stop_test();
    $display("checks %0d bad %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic t_addr();
    logic [7:0] ov;
    {EXT_MEMORY_ENABLE, ADDRESS_HIGH, PORTC_OUT, PORTC_DIR} = {1'b1, 8'hA5, 8'h3C, 8'h0F};
    for (int m = 0; m < 8; m++) begin
      HIGH_ADDRESS_MASK = m[2:0];
      for (int g = 0; g < 8; g++) ov[g] = (m < (g == 0 ? 7 : 8 - g));
      tick(1);
      `CHK("c_oe", ov | 8'h0F, PORTC_OE)
      `CHK("c_out", (8'hA5 & ov) | (8'h3C & ~ov), PORTC_PIN_OUT)
      `CHK("c_pu", 8'h30 & ~ov, PORTC_PULLUP)
    end
    $display("t_addr done");
  endtask
  task automatic t_compat();
    {COMPAT_MODE, EXT_MEMORY_ENABLE, HIGH_ADDRESS_MASK, PORTC_DIR} = {2'b11, 3'h7, 8'h00};
    {SECOND_UART_TX_ENABLE, TWO_WIRE_ENABLE, SDA_OUT} = 3'b111;
    tick(1);
    `CHK("cm_oe", 8'hFF, PORTC_OE)
    `CHK("cm_out", 8'hA5, PORTC_PIN_OUT)
    `CHK("cm_d_oe", 4'h0, PORTD_OE[3:0])
    EXT_MEMORY_ENABLE = 1'b0;
    tick(1);
    `CHK("cm_oe_idle", 8'hFF, PORTC_OE)
    `CHK("cm_pu", 8'h00, PORTC_PULLUP)
    {COMPAT_MODE, SECOND_UART_TX_ENABLE, TWO_WIRE_ENABLE, SDA_OUT} = 4'h0;
    $display("t_compat done");
  endtask
  task automatic t_uart();
    {PORTD_DIR, PORTD_OUT} = {8'h24, 8'h04};
    {SECOND_UART_TX_ENABLE, SECOND_UART_RX_ENABLE, SECOND_UART_SYNC_SELECT} = 3'b111;
    for (int v = 0; v < 2; v++) begin
      {SECOND_UART_TX_DATA, SECOND_UART_CLOCK_OUT} = {2{v[0]}};
      tick(1);
      `CHK("u_oe", 4'hA, PORTD_OE[5:2])
      `CHK("u_val", {2{v[0]}}, {PORTD_PIN_OUT[5], PORTD_PIN_OUT[3]})
      `CHK("u_pu", 2'h1, PORTD_PULLUP[3:2])
    end
    {GLOBAL_PULLUP_DISABLE, PORTD_DIR} = {1'b1, 8'h00};
    tick(1);
    `CHK("u_pud", 1'b0, PORTD_PULLUP[2])
    `CHK("u_ck_in", 1'b0, PORTD_OE[5])
    {GLOBAL_PULLUP_DISABLE, SECOND_UART_TX_ENABLE, SECOND_UART_RX_ENABLE, SECOND_UART_SYNC_SELECT} = 4'h0;
    tick(1);
    `CHK("u_async", 1'b0, PORTD_PIN_OUT[5])
    `CHK("u_tx_off", 1'b0, PORTD_OE[3])
    $display("t_uart done");
  endtask
  task automatic t_tw();
    {PORTD_OUT, TWO_WIRE_ENABLE, SDA_OUT, SCL_OUT} = {8'h03, 3'b110};
    tick(6);
    `CHK("tw_oe", 2'h2, PORTD_OE[1:0])
    `CHK("tw_val", 2'h0, PORTD_PIN_OUT[1:0])
    `CHK("tw_slew", 2'h3, PORTD_SLEW_LIMIT[1:0])
    `CHK("tw_in", 2'h1, {SDA_IN, SCL_IN})
    SDA_OUT = 1'b0;
    tick(6);
    // One-cycle low pulse, 20 ns, shorter than the filter window
    ext_en[1] = 1'b1;
    tick(1);
    ext_en[1] = 1'b0;
    repeat (6) begin
      tick(1);
      `CHK("tw_glitch", 1'b1, SDA_IN)
    end
    ext_en[1] = 1'b1;
    tick(6);
    `CHK("tw_low", 1'b0, SDA_IN)
    {ext_en, TWO_WIRE_ENABLE} = '0;
    tick(6);
    $display("t_tw done");
  endtask
  task automatic t_int_timer();
    {EXT_INT_ENABLE, ext_en, ext_val} = {4'hF, 8'hFF, 8'hB5};
    tick(3);
    `CHK("int_ie", 4'hF, PORTD_INPUT_EN[3:0])
    `CHK("int_in", 4'h5, EXT_INT_IN)
    `CHK("d_in", 8'hB5, PORTD_DATA_IN)
    `CHK("rx_data", 1'b1, SECOND_UART_RX_DATA)
    `CHK("ck_in", 1'b1, SECOND_UART_CLOCK_IN)
    `CHK("tm_ext", 3'h5, {TIMER2_CLOCK_INPUT, TIMER1_CLOCK_INPUT, TIMER1_CAPTURE_INPUT})
    {PORTD_DIR, PORTD_OUT, ext_en} = {8'hD0, 8'h50, 8'h00};
    tick(3);
    `CHK("tm_oe", 8'hD0, PORTD_OE & 8'hD0)
    `CHK("tm_own", 3'h3, {TIMER2_CLOCK_INPUT, TIMER1_CLOCK_INPUT, TIMER1_CAPTURE_INPUT})
    $display("t_int_timer done");
  endtask
  // ==========================================
  // Sequence
  initial begin
    {RST_N, COMPAT_MODE, EXT_MEMORY_ENABLE, GLOBAL_PULLUP_DISABLE, HIGH_ADDRESS_MASK, ADDRESS_HIGH} = '0;
    {PORTC_OUT, PORTC_DIR, PORTD_OUT, PORTD_DIR, ext_en, ext_val, EXT_INT_ENABLE} = '0;
    {SECOND_UART_TX_ENABLE, SECOND_UART_RX_ENABLE, SECOND_UART_SYNC_SELECT, SECOND_UART_TX_DATA} = '0;
    {SECOND_UART_CLOCK_OUT, TWO_WIRE_ENABLE, SDA_OUT, SCL_OUT} = '0;
    tick(12);
    `CHK("rst_oe", 8'h00, PORTC_OE)
    `CHK("rst_sda", 1'b1, SDA_IN)
    RST_N = 1'b1;
    t_addr();
    t_compat();
    t_uart();
    t_tw();
    t_int_timer();
    stop_test();
  end
  // Tests take well under 200 cycles
  initial begin
    #100000;
    bad_count++;
    stop_test();
  end
endmodule // pcd_port_override_tb_top
